//--- design/fp_bitscan_ctrlreg_exec.sv
/*
  Execution block for float multiply, int-to-float, bit scans and float control
  register load/store, reached over an AHB-Lite slave port.
  Assumes one master, whole-word single transfers, and that general registers are
  staged by software in the source words before the go strobe.
*/
`timescale 1ns/1ps
module fp_bitscan_ctrlreg_exec (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // general register writeback
  output logic WB_VALID,
  output logic [4:0] WB_INDEX,
  output logic [63:0] WB_DATA,
  output logic WB_DOUBLE,
  // exception pulse vector
  output logic [fp_exec_pkg::EXC_W-1:0] EXC
);
  import fp_exec_pkg::*;

  // highest bit equal to want, or 32 when none matches
  function automatic logic [5:0] scan(input logic [31:0] v, input logic want);
    logic [5:0] r;
    r = SCAN_NONE;
    for (int i = 0; i < 32; i++) begin
      if (v[i] == want) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // infinities, nans and denormals are left to software
  function automatic logic resv(input logic [31:0] f);
    return (f[30:23] == 8'hff) || (f[30:23] == 8'h00 && f[22:0] != 23'h0);
  endfunction

  logic [31:0] instr_q, src1_q, src2_q, fcr0_q, fp_status_reg_q, fp_control_reg_q, hrdata_q;
  logic [1:0] ctrl_q;
  logic [7:0] status_q, wb_reg_q;
  logic [63:0] res_q;
  logic wr_pend_q, hready_q, hresp_q;
  logic [7:0] wr_addr_q;
  logic wb_valid_q, wb_dbl_q;
  logic [4:0] wb_idx_q;
  logic [EXC_W-1:0] exc_q;

  // bus address phase
  wire addr_ok = HSEL && HREADY && HTRANS[1];
  wire [7:0] a_ofs = HADDR[7:0];
  wire a_hit = (HADDR[31:8] == 24'h0) && (HADDR[1:0] == 2'b00);
  wire go = wr_pend_q && (wr_addr_q == OFS_GO);

  // field extraction
  wire [5:0] fam = instr_q[31:26];
  wire [4:0] sub = instr_q[15:11];
  wire [4:0] d_fld = instr_q[25:21];
  wire [1:0] src_one_precision = instr_q[10:9];
  wire [1:0] src_two_precision = instr_q[8:7];
  wire [1:0] dest_precision = instr_q[6:5];
  wire [5:0] ctrl_src_selector = instr_q[10:5];
  wire [5:0] ctrl_dst_selector = instr_q[10:5];
  wire supervisor = ctrl_q[CTRL_SUPER];
  wire fpu_en = ctrl_q[CTRL_FPU_EN];

  // decode; bits 20..16 of scans/loads and 25..21 of stores are never looked at
  wire is_tri = fam == OP_FP_TRI;
  wire is_scan = (fam == OP_BITFLD) && (sub == SCAN_HI) &&
                 (instr_q[9:5] == SCAN_LO);
  wire is_flt = is_tri && (sub == SUB_FLT) && (instr_q[20:16] == 5'h0) &&
                (instr_q[10:7] == 4'h0);
  op_t op;
  assign op = (is_tri && sub == SUB_FMUL) ? OPK_MUL :
              is_flt ? OPK_FLT :
              (is_tri && sub == SUB_FDIV) ? OPK_DIV :
              (is_scan && instr_q[10]) ? OPK_FF0 :
              is_scan ? OPK_FF1 :
              (fam == OP_FP_CR && sub == SUB_LDCR) ? OPK_LDCR :
              (fam == OP_FP_CR && sub == SUB_STCR) ? OPK_STCR : OPK_NONE;

  // precision checks; double operands go to the software path
  wire prec_bad = (src_one_precision > PREC_DBL) || (src_two_precision > PREC_DBL) ||
                  (dest_precision > PREC_DBL);
  wire mul_dbl = (src_one_precision == PREC_DBL) || (src_two_precision == PREC_DBL) ||
                 (dest_precision == PREC_DBL);
  wire unimp_base = (d_fld == 5'h0) || !fpu_en;

  // single precision multiply, truncating
  wire [23:0] ma = {1'b1, src1_q[22:0]};
  wire [23:0] mb = {1'b1, src2_q[22:0]};
  wire [47:0] prod = ma * mb;
  wire mul_zero = (src1_q[30:23] == 8'h0) || (src2_q[30:23] == 8'h0);
  wire mul_sign = src1_q[31] ^ src2_q[31];
  wire signed [10:0] mul_exp = {3'b000, src1_q[30:23]} + {3'b000, src2_q[30:23]} -
                               SGL_BIAS + {10'h0, prod[47]};
  wire [22:0] mul_man = prod[47] ? prod[46:24] : prod[45:23];
  wire mul_lost = prod[47] ? (prod[23:0] != 24'h0) : (prod[22:0] != 23'h0);
  wire mul_ovf = !mul_zero && (mul_exp >= SGL_EXP_MAX);
  wire mul_unf = !mul_zero && (mul_exp <= 11'sd0);
  wire mul_inx = !mul_zero && mul_lost;
  wire [31:0] mul_res = mul_zero ? {mul_sign, 31'h0} :
                        {mul_sign, mul_exp[7:0], mul_man};
  wire mul_resv = resv(src1_q) || resv(src2_q);

  // signed integer to float, truncating
  wire flt_neg = src2_q[31];
  wire [31:0] flt_mag = flt_neg ? 32'(-src2_q) : src2_q;
  wire [5:0] flt_pos = scan(flt_mag, 1'b1);
  wire [31:0] flt_norm = flt_mag << (5'd31 - flt_pos[4:0]);
  wire flt_zero = flt_mag == 32'h0;
  wire [10:0] flt_es = SGL_BIAS + {5'h0, flt_pos};
  wire [10:0] flt_ed = DBL_BIAS + {5'h0, flt_pos};
  wire [31:0] flt_sgl = flt_zero ? 32'h0 : {flt_neg, flt_es[7:0], flt_norm[30:8]};
  wire [63:0] flt_dbl = flt_zero ? 64'h0 :
                        {flt_neg, flt_ed, flt_norm[30:0], 21'h0};
  wire flt_inx = (dest_precision == PREC_SGL) && (flt_norm[7:0] != 8'h0);

  // control register access
  wire [5:0] cr_idx = (op == OPK_STCR) ? ctrl_dst_selector : ctrl_src_selector;
  wire cr_open = (cr_idx == FCR_STATUS) || (cr_idx == FCR_CONTROL);
  wire cr_priv_fail = !supervisor && !cr_open;
  wire [31:0] cr_rd = (cr_idx == 6'd0) ? fcr0_q :
                      (cr_idx == FCR_STATUS) ? fp_status_reg_q :
                      (cr_idx == FCR_CONTROL) ? fp_control_reg_q : 32'h0;
  wire inx_en = fp_control_reg_q[FP_CONTROL_REG_INX_EN];

  // one instruction, evaluated in the go cycle
  logic [EXC_W-1:0] exc_d;
  logic wb_en_d, wb_dbl_d, sticky_d;
  logic [63:0] wb_data_d;
  logic [1:0] cr_wr_d;
  always_comb begin
    exc_d = '0;
    wb_en_d = 1'b0;
    wb_dbl_d = 1'b0;
    sticky_d = 1'b0;
    wb_data_d = 64'h0;
    cr_wr_d = 2'b00;
    case (op)
      OPK_MUL: begin
        if (unimp_base || mul_dbl || prec_bad) begin
          exc_d[EXC_UNIMP] = 1'b1;
        end else if (mul_resv) begin
          exc_d[EXC_RESOP] = 1'b1;
        end else if (mul_ovf || mul_unf) begin
          exc_d[EXC_OVF] = mul_ovf;
          exc_d[EXC_UNF] = mul_unf;
          exc_d[EXC_INX] = mul_inx && inx_en;
        end else if (mul_inx && inx_en) begin
          exc_d[EXC_INX] = 1'b1;
        end else begin
          wb_en_d = 1'b1;
          wb_data_d = {32'h0, mul_res};
          sticky_d = mul_inx;
        end
      end
      OPK_FLT: begin
        if (unimp_base || dest_precision > PREC_DBL) begin
          exc_d[EXC_UNIMP] = 1'b1;
        end else if (flt_inx && inx_en) begin
          exc_d[EXC_INX] = 1'b1;
        end else begin
          wb_en_d = 1'b1;
          wb_dbl_d = dest_precision == PREC_DBL;
          wb_data_d = wb_dbl_d ? flt_dbl : {32'h0, flt_sgl};
          sticky_d = flt_inx;
        end
      end
      OPK_FF0: begin
        wb_en_d = 1'b1;
        wb_data_d = {58'h0, scan(src2_q, 1'b0)};
      end
      OPK_FF1: begin
        wb_en_d = 1'b1;
        wb_data_d = {58'h0, scan(src2_q, 1'b1)};
      end
      OPK_LDCR: begin
        if (cr_priv_fail) begin
          exc_d[EXC_PRIV] = 1'b1;
        end else begin
          wb_en_d = 1'b1;
          wb_data_d = {32'h0, cr_rd};
        end
      end
      OPK_STCR: begin
        if (cr_priv_fail) begin
          exc_d[EXC_PRIV] = 1'b1;
        end else if (cr_idx == 6'd0) begin
          cr_wr_d = 2'b01;
        end else if (cr_idx == FCR_STATUS) begin
          cr_wr_d = 2'b10;
        end else if (cr_idx == FCR_CONTROL) begin
          cr_wr_d = 2'b11;
        end else begin
          cr_wr_d = 2'b00;
        end
      end
      default: begin
        exc_d[EXC_ILL] = 1'b1;
      end
    endcase
  end

  // register read mux for the address phase
  logic [31:0] rd_d;
  always_comb begin
    if (!a_hit) begin
      rd_d = 32'h0;
    end else if (a_ofs == OFS_INSTR) begin
      rd_d = instr_q;
    end else if (a_ofs == OFS_SRC1) begin
      rd_d = src1_q;
    end else if (a_ofs == OFS_SRC2) begin
      rd_d = src2_q;
    end else if (a_ofs == OFS_CTRL) begin
      rd_d = {30'h0, ctrl_q};
    end else if (a_ofs == OFS_STATUS) begin
      rd_d = {24'h0, status_q};
    end else if (a_ofs == OFS_RES_LO) begin
      rd_d = res_q[31:0];
    end else if (a_ofs == OFS_RES_HI) begin
      rd_d = res_q[63:32];
    end else if (a_ofs == OFS_WB) begin
      rd_d = {24'h0, wb_reg_q};
    end else if (a_ofs == OFS_FCR0) begin
      rd_d = fcr0_q;
    end else if (a_ofs == OFS_FP_STATUS_REG) begin
      rd_d = fp_status_reg_q;
    end else if (a_ofs == OFS_FP_CONTROL_REG) begin
      rd_d = fp_control_reg_q;
    end else begin
      rd_d = 32'h0;
    end
  end

  wire wr_instr = wr_pend_q && wr_addr_q == OFS_INSTR;
  wire wr_src1 = wr_pend_q && wr_addr_q == OFS_SRC1;
  wire wr_src2 = wr_pend_q && wr_addr_q == OFS_SRC2;
  wire wr_ctrl = wr_pend_q && wr_addr_q == OFS_CTRL;
  // the store source is taken from source one only; the duplicate in source two
  // is the program's duty and goes unchecked
  wire [31:0] st_val = src1_q;
  // a bus write to a control register loses to an instruction in the same cycle
  wire bus_fcr0 = wr_pend_q && wr_addr_q == OFS_FCR0;
  wire bus_fp_status_reg = wr_pend_q && wr_addr_q == OFS_FP_STATUS_REG;
  wire bus_fp_control_reg = wr_pend_q && wr_addr_q == OFS_FP_CONTROL_REG;
  wire set_sticky = go && sticky_d && !inx_en;

  // bus slave state
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata_q <= 32'h0;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && HWRITE && a_hit;
      wr_addr_q <= a_ofs;
      hrdata_q <= (addr_ok && !HWRITE) ? rd_d : 32'h0;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // software-visible staging registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      instr_q <= 32'h0;
      src1_q <= 32'h0;
      src2_q <= 32'h0;
      ctrl_q <= CTRL_RST;
    end else begin
      instr_q <= wr_instr ? HWDATA : instr_q;
      src1_q <= wr_src1 ? HWDATA : src1_q;
      src2_q <= wr_src2 ? HWDATA : src2_q;
      ctrl_q <= wr_ctrl ? HWDATA[1:0] : ctrl_q;
    end
  end

  // float control registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      fcr0_q <= FCR_RST;
      fp_status_reg_q <= FCR_RST;
      fp_control_reg_q <= FCR_RST;
    end else begin
      if (go && cr_wr_d == 2'b01) begin
        fcr0_q <= st_val;
      end else if (bus_fcr0) begin
        fcr0_q <= HWDATA;
      end
      if (go && cr_wr_d == 2'b10) begin
        fp_status_reg_q <= st_val;
      end else if (bus_fp_status_reg) begin
        fp_status_reg_q <= HWDATA;
      end else if (set_sticky) begin
        fp_status_reg_q[FP_STATUS_REG_INX_STICKY] <= 1'b1;
      end
      if (go && cr_wr_d == 2'b11) begin
        fp_control_reg_q <= st_val;
      end else if (bus_fp_control_reg) begin
        fp_control_reg_q <= HWDATA;
      end
    end
  end

  // results of the last instruction
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      status_q <= 8'h0;
      res_q <= 64'h0;
      wb_reg_q <= 8'h0;
      wb_valid_q <= 1'b0;
      wb_dbl_q <= 1'b0;
      wb_idx_q <= 5'h0;
      exc_q <= '0;
    end else begin
      wb_valid_q <= go && wb_en_d;
      exc_q <= go ? exc_d : '0;
      if (go) begin
        status_q <= {exc_d, 1'b1};
        res_q <= wb_data_d;
        wb_reg_q <= {1'b0, wb_dbl_d, wb_en_d, d_fld};
        wb_dbl_q <= wb_dbl_d;
        wb_idx_q <= d_fld;
      end
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP = hresp_q;
  assign WB_VALID = wb_valid_q;
  assign WB_INDEX = wb_idx_q;
  assign WB_DATA = res_q;
  assign WB_DOUBLE = wb_dbl_q;
  assign EXC = exc_q;
endmodule

//--- design/fp_exec_pkg.sv
/*
  Constants for the floating-point / bit-scan / control-register execution block:
  bus offsets, instruction encodings, control register indices, exception bits.
  Assumes a single core clock and an AHB-Lite master issuing whole-word singles.
*/
// Function
// - precision fields 00 mean single, 01 mean double, for every operand.
// - multiply or int-to-float with r0 destination or unit disabled is unimplemented.
// - first-clear scan looks from bit 31 down and writes the zero's index.
// - first-clear scan over an all-ones word writes 32.
// - first-set scan looks from bit 31 down and writes the one's index.
// - first-set scan over an all-zeros word writes 32.
// - reserved-zero fields of scans, loads and stores are not decoded.
// - scans match a fixed bits 15..5 pattern; bit 10 picks set or clear.
// - control load copies the register picked by bits 10..5 into rD.
// - control registers 0..8 are supervisor only; user access is a privilege fault.
// - control 63 and status 62 are open to user and supervisor.
// - load of 9..61 gives zero for supervisor, privilege fault for user.
// - control store writes source-one into the register picked by bits 10..5.
// - stores to read-only 1..8 change nothing.
// - store to 9..61 is a no-op for supervisor, privilege fault for user.
// - int-to-float converts signed source two to single or double per destination size.
// - int-to-float and multiply fault on inexact only when inexact is unmasked.
// - multiply faults on reserved operands after the unimplemented checks, else multiplies and writes rD.
// - multiply faults on overflow, underflow or, when inexact is unmasked, inexact results.
package fp_exec_pkg;
  // bus offsets (byte addresses)
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_SRC1 = 8'h04;
  localparam logic [7:0] OFS_SRC2 = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_GO = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RES_LO = 8'h18;
  localparam logic [7:0] OFS_RES_HI = 8'h1c;
  localparam logic [7:0] OFS_WB = 8'h20;
  localparam logic [7:0] OFS_FCR0 = 8'h24;
  localparam logic [7:0] OFS_FP_STATUS_REG = 8'h28;
  localparam logic [7:0] OFS_FP_CONTROL_REG = 8'h2c;
  // ctrl fields
  localparam int CTRL_SUPER = 0;
  localparam int CTRL_FPU_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  // exception vector positions
  localparam int EXC_W = 7;
  localparam int EXC_UNIMP = 0;
  localparam int EXC_PRIV = 1;
  localparam int EXC_RESOP = 2;
  localparam int EXC_OVF = 3;
  localparam int EXC_UNF = 4;
  localparam int EXC_INX = 5;
  localparam int EXC_ILL = 6;
  // status: done in bit 0, exceptions above it
  localparam int STAT_DONE = 0;
  localparam int STAT_EXC_LSB = 1;
  // control register fields
  localparam int FP_CONTROL_REG_INX_EN = 0;
  localparam int FP_STATUS_REG_INX_STICKY = 0;
  localparam logic [31:0] FCR_RST = 32'h0;
  // instruction encodings
  localparam logic [5:0] OP_FP_TRI = 6'h21;
  localparam logic [5:0] OP_FP_CR = 6'h20;
  localparam logic [5:0] OP_BITFLD = 6'h3d;
  localparam logic [4:0] SUB_FMUL = 5'h00;
  localparam logic [4:0] SUB_FLT = 5'h04;
  localparam logic [4:0] SUB_FDIV = 5'h0e;
  localparam logic [4:0] SUB_LDCR = 5'h09;
  localparam logic [4:0] SUB_STCR = 5'h11;
  localparam logic [4:0] SCAN_HI = 5'h1d;
  localparam logic [4:0] SCAN_LO = 5'h00;
  localparam logic [1:0] PREC_SGL = 2'h0;
  localparam logic [1:0] PREC_DBL = 2'h1;
  // control register indices
  localparam logic [5:0] FCR_PRIV_LAST = 6'd8;
  localparam logic [5:0] FCR_STATUS = 6'd62;
  localparam logic [5:0] FCR_CONTROL = 6'd63;
  // float formats
  localparam logic [10:0] SGL_BIAS = 11'd127;
  localparam logic [10:0] DBL_BIAS = 11'd1023;
  localparam logic signed [10:0] SGL_EXP_MAX = 11'sd255;
  localparam logic [5:0] SCAN_NONE = 6'd32;

  typedef enum logic [2:0] {
    OPK_NONE, OPK_MUL, OPK_FLT, OPK_DIV, OPK_FF0, OPK_FF1, OPK_LDCR, OPK_STCR
  } op_t;
endpackage

//--- tb/fp_bitscan_ctrlreg_exec_tb.sv
/*
  Self-checking bench: AHB-Lite master tasks, random and corner bit scans,
  control register access in both modes, multiply and int-to-float.
  Assumes zero-wait-state answers and a register-file partner on writeback.
*/
`timescale 1ns/1ps
module fp_bitscan_ctrlreg_exec_tb;
  import fp_exec_pkg::*;
  localparam logic [6:0] XU = 7'h1 << EXC_UNIMP;
  localparam logic [6:0] XP = 7'h1 << EXC_PRIV;
  localparam logic [6:0] XI = 7'h1 << EXC_INX;
  localparam logic [1:0] SUP = 2'h3;
  localparam logic [1:0] USR = 2'h2;
  logic CORE_CLK = 1'b0;
  logic SRST = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic WB_VALID;
  logic WB_DOUBLE;
  logic [4:0] WB_INDEX;
  logic [63:0] WB_DATA;
  logic [EXC_W-1:0] EXC;
  logic [63:0] last_data;
  logic [31:0] n_wr;
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] mi;
  logic [31:0] fi;
  logic clr;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'hd7082e18;
  logic [5:0] sels [4] = '{6'd1, 6'd8, 6'd9, 6'd61};
  fp_bitscan_ctrlreg_exec fp_bitscan_ctrlreg_exec_inst (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WB_VALID(WB_VALID), .WB_INDEX(WB_INDEX),
    .WB_DATA(WB_DATA), .WB_DOUBLE(WB_DOUBLE), .EXC(EXC)
  );
  gpr_model gpr_model_inst (
    .clk(CORE_CLK), .srst(SRST), .wb_valid(WB_VALID), .wb_index(WB_INDEX),
    .wb_data(WB_DATA), .last_data(last_data), .n_wr(n_wr)
  );
  initial begin
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge CORE_CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        results();
      end
      @(posedge CORE_CLK);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(64'(rd), 64'(exp));
    check(64'(HRESP), 64'h0);
  endtask
  // stage operands, fire, then look at the one-cycle pulses and the partner
  task automatic exec(input logic [31:0] ins, input logic [31:0] s1, input logic [31:0] s2,
      input logic [1:0] ctl, input logic [6:0] xe, input logic wb, input logic [63:0] d);
    logic [31:0] n0;
    xfer(1'b1, OFS_INSTR, ins);
    xfer(1'b1, OFS_SRC1, s1);
    xfer(1'b1, OFS_SRC2, s2);
    xfer(1'b1, OFS_CTRL, {30'h0, ctl});
    n0 = n_wr;
    xfer(1'b1, OFS_GO, 32'h0);
    #1;
    check(64'(EXC), 64'(xe));
    check(64'(WB_VALID), 64'(wb));
    if (wb) begin
      check(WB_DATA, d);
      check(64'(WB_INDEX), 64'(ins[25:21]));
      check(64'(WB_DOUBLE), 64'(|d[63:32]));
    end
    @(posedge CORE_CLK);
    rchk(OFS_STATUS, {24'h0, xe, 1'b1});
    check(64'(n_wr - n0), 64'(wb));
    if (wb) check(last_data, d);
  endtask
  function automatic logic [63:0] scan_exp(input logic c, input logic [31:0] x);
    scan_exp = 64'd32;
    for (int i = 31; i >= 0; i--) begin
      if (x[i] != c && scan_exp == 64'd32) scan_exp = 64'(i);
    end
  endfunction
  function automatic logic [31:0] scan_i(input logic c, input logic [4:0] d,
      input logic [4:0] z);
    return {OP_BITFLD, d, z, SCAN_HI, c, 5'h0, 5'h2};
  endfunction
  function automatic logic [31:0] cr_i(input logic st, input logic [4:0] r, input logic [5:0] f);
    return st ? {OP_FP_CR, 5'h0, r, SUB_STCR, f, r} : {OP_FP_CR, r, 5'h0, SUB_LDCR, f, 5'h0};
  endfunction
  function automatic logic [31:0] fp_i(input logic [4:0] sub, input logic [4:0] d,
      input logic [1:0] td);
    if (sub == SUB_FLT) return {OP_FP_TRI, d, 5'h0, sub, 4'h0, td, 5'h2};
    return {OP_FP_TRI, d, 5'h1, sub, PREC_SGL, PREC_SGL, td, 5'h2};
  endfunction
  initial begin
    #1500000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (10) @(posedge CORE_CLK);
    SRST <= 1'b0;
    rchk(OFS_CTRL, {30'h0, CTRL_RST});
    rchk(OFS_FP_CONTROL_REG, FCR_RST);
    rchk(8'h30, 32'h0);
    for (int k = 0; k < 24; k++) begin
      v = (k == 0 || k == 2) ? 32'hffffffff : (k < 4 ? 32'h0 : $random(seed));
      clr = k < 4 ? (k == 0 || k == 3) : 1'($random(seed));
      exec(scan_i(clr, 5'($random(seed)), 5'($random(seed))), '0, v, 2'($random(seed)),
          '0, 1'b1, scan_exp(clr, v));
    end
    exec(cr_i(1'b1, 5'h3, FCR_CONTROL), 32'ha5a4, '0, USR, '0, 1'b0, '0);
    rchk(OFS_FP_CONTROL_REG, 32'ha5a4);
    exec(cr_i(1'b0, 5'h9, FCR_CONTROL), '0, '0, USR, '0, 1'b1, 64'ha5a4);
    exec(cr_i(1'b1, 5'h4, FCR_STATUS), 32'h0f00, '0, USR, '0, 1'b0, '0);
    rchk(OFS_FP_STATUS_REG, 32'h0f00);
    exec(cr_i(1'b1, 5'h5, 6'd0), 32'h12, '0, USR, XP, 1'b0, '0);
    exec(cr_i(1'b0, 5'h6, 6'd0), '0, '0, USR, XP, 1'b0, '0);
    rchk(OFS_FCR0, 32'h0);
    exec(cr_i(1'b1, 5'h5, 6'd0), 32'h12, '0, SUP, '0, 1'b0, '0);
    exec(cr_i(1'b0, 5'h6, 6'd0), '0, '0, SUP, '0, 1'b1, 64'h12);
    foreach (sels[j]) begin
      exec(cr_i(1'b1, 5'h7, sels[j]), 32'hffff, '0, SUP, '0, 1'b0, '0);
      exec(cr_i(1'b1, 5'h7, sels[j]), 32'hffff, '0, USR, XP, 1'b0, '0);
      exec(cr_i(1'b0, 5'h8, sels[j]), '0, '0, SUP, '0, 1'b1, '0);
      exec(cr_i(1'b0, 5'h8, sels[j]), '0, '0, USR, XP, 1'b0, '0);
    end
    rchk(OFS_FP_CONTROL_REG, 32'ha5a4);
    rchk(OFS_FCR0, 32'h12);
    mi = fp_i(SUB_FMUL, 5'h4, PREC_SGL);
    fi = fp_i(SUB_FLT, 5'h4, PREC_SGL);
    exec(mi, 32'h40000000, 32'h40400000, USR, '0, 1'b1, 64'h40c00000);
    exec(fp_i(SUB_FMUL, 5'h0, PREC_SGL), 32'h40000000, 32'h3f800000, USR, XU, 1'b0, '0);
    exec(mi, 32'h40000000, 32'h3f800000, 2'h1, XU, 1'b0, '0);
    exec(mi, 32'h7f800000, 32'h40000000, USR, 7'h1 << EXC_RESOP, 1'b0, '0);
    exec(mi, 32'h7f000000, 32'h7f000000, USR, 7'h1 << EXC_OVF, 1'b0, '0);
    exec(mi, 32'h00800000, 32'h00800000, USR, 7'h1 << EXC_UNF, 1'b0, '0);
    exec(mi, 32'h3f800001, 32'h3f800001, USR, '0, 1'b1, 64'h3f800002);
    exec(fi, '0, 32'h01000001, USR, '0, 1'b1, 64'h4b800000);
    rchk(OFS_FP_STATUS_REG, 32'h0f01);
    exec(fi, '0, 32'h5, USR, '0, 1'b1, 64'h40a00000);
    exec(fp_i(SUB_FLT, 5'h4, PREC_DBL), '0, 32'hffffffff, USR, '0, 1'b1,
        64'hbff0000000000000);
    exec(fp_i(SUB_FLT, 5'h0, PREC_SGL), '0, 32'h5, USR, XU, 1'b0, '0);
    xfer(1'b1, OFS_FP_CONTROL_REG, 32'h1);
    exec(mi, 32'h3f800001, 32'h3f800001, USR, XI, 1'b0, '0);
    exec(fi, '0, 32'h01000001, USR, XI, 1'b0, '0);
    results();
  end
endmodule

//--- tb/fp_exec_asserts.sv
/*
  Checker for the execution block, seeing only its ports.
  Assumes hready is the block's own hreadyout and whole-word singles.
*/
`timescale 1ns/1ps
module fp_exec_asserts (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  // results
  input wire logic WB_VALID,
  input wire logic [63:0] WB_DATA,
  input wire logic [fp_exec_pkg::EXC_W-1:0] EXC
);
  import fp_exec_pkg::*;
  logic [7:0] a_q;
  logic wr_q;
  logic [31:0] ins_q;
  logic [31:0] s2_q;
  logic [1:0] ctl_q;
  // shadow of the staged words, so expectations follow bus writes
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_q <= 1'b0;
      a_q <= 8'h0;
      ins_q <= 32'h0;
      s2_q <= 32'h0;
      ctl_q <= CTRL_RST;
    end else begin
      wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[31:8] == 24'h0;
      a_q <= HADDR[7:0];
      if (wr_q && a_q == OFS_INSTR) ins_q <= HWDATA;
      if (wr_q && a_q == OFS_SRC2) s2_q <= HWDATA;
      if (wr_q && a_q == OFS_CTRL) ctl_q <= HWDATA[1:0];
    end
  end
  function automatic logic [5:0] top_one(input logic [31:0] v);
    top_one = 6'd32;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) top_one = 6'(i);
    end
  endfunction
  wire go = wr_q && a_q == OFS_GO;
  wire [4:0] sub = ins_q[15:11];
  wire [5:0] sel = ins_q[10:5];
  wire scan = ins_q[31:26] == OP_BITFLD && sub == SCAN_HI && ins_q[9:5] == 5'h0;
  wire cr = ins_q[31:26] == OP_FP_CR && (sub == SUB_LDCR || sub == SUB_STCR);
  wire ld = cr && sub == SUB_LDCR;
  wire mul = ins_q[31:26] == OP_FP_TRI && sub == SUB_FMUL;
  wire [5:0] f_set = top_one(s2_q);
  wire [5:0] f_clr = top_one(~s2_q);
  wire sup = ctl_q[CTRL_SUPER];
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_wrote(logic [63:0] v);
    WB_VALID && EXC == '0 && WB_DATA == v;
  endsequence
  AST_SCAN_CLR: assert property (go && scan && ins_q[10] |=> s_wrote(64'($past(f_clr))))
    else $error("clear scan result wrong");
  AST_SCAN_SET: assert property (go && scan && !ins_q[10] |=> s_wrote(64'($past(f_set))))
    else $error("set scan result wrong");
  AST_MUL_UNIMP: assert property (go && mul && (ins_q[25:21] == 5'h0 || !ctl_q[CTRL_FPU_EN])
    |=> EXC[EXC_UNIMP] && !WB_VALID) else $error("multiply not unimplemented");
  AST_PRIV_USER: assert property (go && cr && !sup && sel < FCR_STATUS
    |=> EXC[EXC_PRIV] && !WB_VALID) else $error("user access not refused");
  AST_OPEN_REGS: assert property (go && cr && sel >= FCR_STATUS |=> EXC == '0)
    else $error("open register faulted");
  AST_LD_ZERO: assert property (go && ld && sup && sel > FCR_PRIV_LAST && sel < FCR_STATUS
    |=> s_wrote(64'h0)) else $error("empty register load not zero");
  AST_ST_NULL: assert property (go && cr && !ld && sup && sel != 6'd0 && sel < FCR_STATUS
    |=> !WB_VALID && EXC == '0) else $error("null store had effect");
  AST_EXC_QUIET: assert property (EXC != '0 |-> !WB_VALID)
    else $error("write despite exception");
endmodule
bind fp_bitscan_ctrlreg_exec fp_exec_asserts fp_exec_asserts_inst (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .WB_VALID(WB_VALID),
  .WB_DATA(WB_DATA), .EXC(EXC)
);

//--- tb/gpr_model.sv
/*
  Register-file partner: takes writebacks from the execution block.
  Assumes writeback strobes are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module gpr_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // writeback
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [63:0] wb_data,
  // observation
  output logic [63:0] last_data,
  output logic [31:0] n_wr
);
  logic [63:0] gpr_q [32];
  always_ff @(posedge clk) begin
    if (srst) begin
      n_wr <= 32'h0;
      last_data <= 64'h0;
    end else if (wb_valid) begin
      gpr_q[wb_index] <= wb_data;
      last_data <= wb_data;
      n_wr <= n_wr + 32'h1;
    end
  end
endmodule
